// file: common/csg_pkg.sv
// package for the call-state and signalling status groups
// assumes one 40 MHz clock and an instrument host issuing status queries
`default_nettype none
package csg_pkg;
  // ==========================================================
  // register widths, selects and masks
  localparam int unsigned CSG_W         = 16;        // every register is 16 bits
  localparam logic [2:0]  CSG_SEL_COND  = 3'h0;      // condition query
  localparam logic [2:0]  CSG_SEL_RISE  = 3'h1;      // rise filter
  localparam logic [2:0]  CSG_SEL_FALL  = 3'h2;      // fall filter
  localparam logic [2:0]  CSG_SEL_EVT   = 3'h3;      // event register
  localparam logic [2:0]  CSG_SEL_ENA   = 3'h4;      // enable register
  localparam logic        CSG_GRP_CALL  = 1'h0;      // call state group
  localparam logic        CSG_GRP_SIG   = 1'h1;      // signalling group
  localparam logic [15:0] CSG_CALL_MASK = 16'h007F;  // bits 6..0 live
  localparam logic [15:0] CSG_SIG_MASK  = 16'h7FFF;  // bit 15 always zero
  localparam logic [15:0] CSG_REG_RST   = 16'h0000;  // value after reset
  // ==========================================================
  // bit positions
  localparam int CSG_CALL_RING  = 6;   // mobile ringing
  localparam int CSG_CALL_CONN  = 5;   // connected
  localparam int CSG_CALL_ACC   = 4;   // access state
  localparam int CSG_CALL_PAGE  = 3;   // paging state
  localparam int CSG_CALL_AUTH  = 2;   // authenticating
  localparam int CSG_CALL_REG   = 1;   // registering
  localparam int CSG_CALL_ACT   = 0;   // call active
  localparam int CSG_SIG_RAMP   = 14;  // power control ramping
  localparam int CSG_SIG_RATE   = 13;  // frame error rate reported
  localparam int CSG_SIG_PILOT  = 12;  // pilot strength message
  localparam int CSG_SIG_REGD   = 11;  // registration completed
  localparam int CSG_SIG_PASS   = 10;  // frame test passed
  localparam int CSG_SIG_FAIL   = 9;   // frame test failed
  localparam int CSG_SIG_MAXF   = 8;   // frame test max frames
  localparam int CSG_SIG_SO2    = 7;   // service option two
  localparam int CSG_SIG_HARD   = 6;   // hard handoff
  localparam int CSG_SIG_SOFTER = 5;   // softer handoff
  localparam int CSG_SIG_ALERT  = 4;   // call alert
  // ==========================================================
  // carriers
  typedef struct packed {
    logic base_call_tried;  // base-originated call attempted
    logic past_access;      // call processing beyond access
    logic answered;         // mobile answered
    logic connected;        // connected indicator
    logic access;           // access indicator
    logic page;             // paging indicator
    logic authenticating;   // authentication running
    logic registering;      // registering indicator
    logic active;           // call active indicator
  } csg_call_ind_type;
  typedef struct packed {
    logic ramping;          // power control ramping
    logic svc_opt2;         // service option two
    logic hard_handoff;     // hard handoff
    logic softer_handoff;   // softer handoff
    logic mobile_ringing;   // mobile_under_test ringing
    logic svc_opt1_orig;    // instrument-originated option one call
    logic rate_report;      // pulse: frame_error_rate reported
    logic pilot_msg;        // pulse: pilot strength message
    logic frame_test_pass;  // pulse: frame test passed
    logic frame_test_fail;  // pulse: frame test failed
    logic frame_test_max;   // pulse: max frame count
  } csg_sig_ind_type;
  typedef struct packed {
    logic        valid;     // query strobe
    logic        grp;       // group select
    logic [2:0]  sel;       // register select
    logic        write;     // 1 write, 0 read
    logic [15:0] data;      // write value
  } csg_cmd_type;
  typedef struct packed {
    logic [15:0] cond;
    logic [15:0] rise;
    logic [15:0] fall;
    logic [15:0] evt;
    logic [15:0] ena;
  } csg_grp_type;
  typedef struct packed {
    csg_grp_type [1:0] grp;   // indexed by group select
    logic              ring;  // ringing latch
    logic              rsp_valid;
    logic [15:0]       rsp_data;
  } csg_state_type;
endpackage
`default_nettype wire

// file: design/csg_status_groups.sv
// call-state and signalling status register groups
// assumes indicators and event pulses come from logic on clk_i
`default_nettype none
module csg_status_groups (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire csg_pkg::csg_call_ind_type call_ind_i,
  input  wire csg_pkg::csg_sig_ind_type  sig_ind_i,
  input  wire csg_pkg::csg_cmd_type      cmd_i,
  input  wire logic                      clear_status_i,
  input  wire logic                      oper_sig_enable_i,
  output logic                           rsp_valid_o,
  output logic [15:0]                    rsp_data_o,
  output logic                           call_summary_o,
  output logic                           sig_summary_o,
  output logic                           sig_status_byte_o
);
  import csg_pkg::*;

  // ==========================================================
  // edge filter and group update
  // event set from filtered edges plus event-only sources
  function automatic logic [15:0] grp_set(input csg_grp_type g,
                                          input logic [15:0] cond_n,
                                          input logic [15:0] only,
                                          input logic [15:0] mask);
    logic [15:0] rise_v;
    logic [15:0] fall_v;
    // edges against the stored condition
    rise_v  = cond_n & ~g.cond;
    fall_v  = ~cond_n & g.cond;
    grp_set = ((rise_v & g.rise) | (fall_v & g.fall) | only) & mask;
  endfunction

  // one cycle of a group: condition, events, host writes
  function automatic csg_grp_type grp_step(input csg_grp_type g,
                                           input logic [15:0] cond_n,
                                           input logic [15:0] set_v,
                                           input logic [15:0] mask,
                                           input csg_cmd_type c,
                                           input logic hit,
                                           input logic cls);
    csg_grp_type r;
    logic        clr;
    r      = g;
    r.cond = cond_n & mask;
    clr    = cls | (hit && !c.write && c.sel == CSG_SEL_EVT);
    r.evt  = (clr ? CSG_REG_RST : g.evt) | set_v;
    // host writes, masked to live bits
    if (hit && c.write) begin
      case (c.sel)
        CSG_SEL_RISE: r.rise = c.data & mask;
        CSG_SEL_FALL: r.fall = c.data & mask;
        CSG_SEL_ENA:  r.ena  = c.data & mask;
        default:      r.ena  = g.ena;                       // cond/event not writable
      endcase
    end
    // hand back the stepped group
    grp_step = r;
  endfunction

  // read mux over one group
  function automatic logic [15:0] grp_read(input csg_grp_type g,
                                           input logic [2:0] sel);
    // unknown selects read zero
    case (sel)
      CSG_SEL_COND: grp_read = g.cond;
      CSG_SEL_RISE: grp_read = g.rise;
      CSG_SEL_FALL: grp_read = g.fall;
      CSG_SEL_EVT:  grp_read = g.evt;
      CSG_SEL_ENA:  grp_read = g.ena;
      default:      grp_read = CSG_REG_RST;
    endcase
  endfunction

  // ==========================================================
  // state
  csg_state_type st_reg;   // all state
  csg_state_type st_next;  // next state
  logic          ring_n;   // next ringing latch
  logic [15:0]   call_c;   // next call condition
  logic [15:0]   sig_c;    // next signalling condition
  logic [15:0]   sig_only; // signalling event-only sources
  logic [15:0]   set_call; // call events set this cycle
  logic [15:0]   set_sig;  // signalling events set this cycle
  logic          hit_call; // query for call group
  logic          hit_sig;  // query for signalling group

  // ==========================================================
  // condition building and register update
  always_comb begin
    // hold everything unless changed below
    st_next = st_reg;
    // ringing latch: answer takes priority, it ends ringing
    ring_n = st_reg.ring;
    if (call_ind_i.base_call_tried && call_ind_i.past_access) begin
      ring_n = 1'b1;
    end
    if (call_ind_i.answered) begin
      ring_n = 1'b0;
    end
    st_next.ring = ring_n;

    // call condition, bits 15..7 held zero
    call_c = CSG_REG_RST;
    call_c[CSG_CALL_RING] = ring_n;
    call_c[CSG_CALL_CONN] = call_ind_i.connected;
    call_c[CSG_CALL_ACC]  = call_ind_i.access;
    call_c[CSG_CALL_PAGE] = call_ind_i.page;
    call_c[CSG_CALL_AUTH] = call_ind_i.authenticating;
    call_c[CSG_CALL_REG]  = call_ind_i.registering;
    call_c[CSG_CALL_ACT]  = call_ind_i.active;

    // signalling condition, only implemented bits
    sig_c = CSG_REG_RST;
    sig_c[CSG_SIG_RAMP]   = sig_ind_i.ramping;
    sig_c[CSG_SIG_SO2]    = sig_ind_i.svc_opt2;
    sig_c[CSG_SIG_HARD]   = sig_ind_i.hard_handoff;
    sig_c[CSG_SIG_SOFTER] = sig_ind_i.softer_handoff;
    sig_c[CSG_SIG_ALERT]  = sig_ind_i.mobile_ringing & sig_ind_i.svc_opt1_orig;

    // event-only bits, no condition behind them
    sig_only = CSG_REG_RST;
    sig_only[CSG_SIG_RATE]  = sig_ind_i.rate_report;
    sig_only[CSG_SIG_PILOT] = sig_ind_i.pilot_msg;
    sig_only[CSG_SIG_REGD]  = st_reg.grp[CSG_GRP_CALL].cond[CSG_CALL_REG]
                              & ~call_ind_i.registering;
    sig_only[CSG_SIG_PASS]  = sig_ind_i.frame_test_pass;
    sig_only[CSG_SIG_FAIL]  = sig_ind_i.frame_test_fail;
    sig_only[CSG_SIG_MAXF]  = sig_ind_i.frame_test_max;

    // filtered event sets
    set_call = grp_set(st_reg.grp[CSG_GRP_CALL], call_c, CSG_REG_RST, CSG_CALL_MASK);
    set_sig  = grp_set(st_reg.grp[CSG_GRP_SIG], sig_c, sig_only, CSG_SIG_MASK);

    // host query decode
    hit_call = cmd_i.valid && cmd_i.grp == CSG_GRP_CALL;
    hit_sig  = cmd_i.valid && cmd_i.grp == CSG_GRP_SIG;

    // read answer uses values before this cycle's update
    st_next.rsp_valid = cmd_i.valid && !cmd_i.write;
    if (cmd_i.valid && !cmd_i.write) begin
      st_next.rsp_data = grp_read(st_reg.grp[cmd_i.grp], cmd_i.sel);
    end

    // both groups step, 16-bit wide each
    st_next.grp[CSG_GRP_CALL] = grp_step(st_reg.grp[CSG_GRP_CALL], call_c, set_call,
                                         CSG_CALL_MASK, cmd_i, hit_call,
                                         clear_status_i);
    st_next.grp[CSG_GRP_SIG]  = grp_step(st_reg.grp[CSG_GRP_SIG], sig_c, set_sig,
                                         CSG_SIG_MASK, cmd_i, hit_sig, clear_status_i);
  end

  // state register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      // reset clears every register
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // outputs
  // read answer from flip-flops, summaries from registers
  assign rsp_valid_o       = st_reg.rsp_valid;
  assign rsp_data_o        = st_reg.rsp_data;
  assign call_summary_o    = |(st_reg.grp[CSG_GRP_CALL].evt & st_reg.grp[CSG_GRP_CALL].ena);
  assign sig_summary_o     = |(st_reg.grp[CSG_GRP_SIG].evt & st_reg.grp[CSG_GRP_SIG].ena);
  assign sig_status_byte_o = sig_summary_o & oper_sig_enable_i;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // all checks are quiet during reset

  AST_RING_SET: assert property (
    call_ind_i.base_call_tried && call_ind_i.past_access && !call_ind_i.answered
    |=> st_reg.grp[CSG_GRP_CALL].cond[CSG_CALL_RING])
    else $error("ringing bit not set");

  // answer ends ringing
  AST_RING_CLR: assert property (
    call_ind_i.answered |=> !st_reg.grp[CSG_GRP_CALL].cond[CSG_CALL_RING])
    else $error("ringing bit not cleared on answer");

  // call bits 5..0 follow indicators
  AST_MIRROR: assert property (
    ##1 st_reg.grp[CSG_GRP_CALL].cond[5:0] ==
    {$past(call_ind_i.connected), $past(call_ind_i.access), $past(call_ind_i.page),
     $past(call_ind_i.authenticating), $past(call_ind_i.registering),
     $past(call_ind_i.active)})
    else $error("call condition does not mirror indicators");

  // authentication bit rises a cycle on
  AST_AUTH: assert property (
    $rose(call_ind_i.authenticating) |=> st_reg.grp[CSG_GRP_CALL].cond[CSG_CALL_AUTH]
    ##0 $rose(st_reg.grp[CSG_GRP_CALL].cond[CSG_CALL_AUTH]))
    else $error("authentication bit late");

  // call bits 15..7 never set
  AST_CALL_UNUSED: assert property (
    ((st_reg.grp[CSG_GRP_CALL].cond | st_reg.grp[CSG_GRP_CALL].evt |
      st_reg.grp[CSG_GRP_CALL].rise | st_reg.grp[CSG_GRP_CALL].fall |
      st_reg.grp[CSG_GRP_CALL].ena) & ~CSG_CALL_MASK) == '0)
    else $error("unused call bits nonzero");

  // call events clear on read or clear
  AST_EVT_CLR: assert property (
    clear_status_i || (hit_call && !cmd_i.write && cmd_i.sel == CSG_SEL_EVT)
    |=> st_reg.grp[CSG_GRP_CALL].evt == $past(set_call))
    else $error("event register not cleared");

  // signalling read returns, then clears
  AST_EVT_RD: assert property (
    hit_sig && !cmd_i.write && cmd_i.sel == CSG_SEL_EVT && !clear_status_i
    |=> rsp_valid_o && rsp_data_o == $past(st_reg.grp[CSG_GRP_SIG].evt)
        && st_reg.grp[CSG_GRP_SIG].evt == $past(set_sig))
    else $error("event read wrong");

  // zero enable silences summary
  AST_ENA_ZERO: assert property (
    hit_call && cmd_i.write && cmd_i.sel == CSG_SEL_ENA && cmd_i.data == '0
    |=> st_reg.grp[CSG_GRP_CALL].ena == '0 ##0 !call_summary_o)
    else $error("enable not cleared by zero write");

  // fall filter write stored masked
  AST_FILTER: assert property (
    hit_sig && cmd_i.write && cmd_i.sel == CSG_SEL_FALL
    |=> st_reg.grp[CSG_GRP_SIG].fall == ($past(cmd_i.data) & CSG_SIG_MASK))
    else $error("filter readback wrong");

  // condition read is side-effect free
  AST_COND_RD: assert property (
    hit_call && !cmd_i.write && cmd_i.sel == CSG_SEL_COND && !clear_status_i
    |=> rsp_data_o == $past(st_reg.grp[CSG_GRP_CALL].cond)
        && st_reg.grp[CSG_GRP_CALL].ena == $past(st_reg.grp[CSG_GRP_CALL].ena))
    else $error("condition read wrong or disturbing");

  // status byte gated by operation enable
  AST_SB_GATE: assert property (
    sig_status_byte_o == (sig_summary_o && oper_sig_enable_i) && (!sig_summary_o ||
    (st_reg.grp[CSG_GRP_SIG].evt & st_reg.grp[CSG_GRP_SIG].ena) != '0))
    else $error("status byte leaks signalling events");

  // bit 15 stuck at zero
  AST_BIT15: assert property (
    !st_reg.grp[CSG_GRP_SIG].cond[15] && !st_reg.grp[CSG_GRP_SIG].evt[15]
    && !st_reg.grp[CSG_GRP_SIG].ena[15] && !st_reg.grp[CSG_GRP_SIG].rise[15])
    else $error("signalling bit 15 set");

  // rate report event
  AST_RATE: assert property (
    sig_ind_i.rate_report |=> st_reg.grp[CSG_GRP_SIG].evt[CSG_SIG_RATE])
    else $error("rate report event missing");

  // pilot message event
  AST_PILOT: assert property (
    sig_ind_i.pilot_msg |=> st_reg.grp[CSG_GRP_SIG].evt[CSG_SIG_PILOT])
    else $error("pilot event missing");

  // registering going off
  AST_REGD: assert property (
    st_reg.grp[CSG_GRP_CALL].cond[CSG_CALL_REG] && !call_ind_i.registering
    |=> st_reg.grp[CSG_GRP_SIG].evt[CSG_SIG_REGD])
    else $error("registered event missing");

  // frame test results, no condition
  AST_FTEST: assert property (
    ##1 (st_reg.grp[CSG_GRP_SIG].evt[10:8] &
    {$past(sig_ind_i.frame_test_pass), $past(sig_ind_i.frame_test_fail),
     $past(sig_ind_i.frame_test_max)}) == {$past(sig_ind_i.frame_test_pass),
     $past(sig_ind_i.frame_test_fail), $past(sig_ind_i.frame_test_max)}
     && st_reg.grp[CSG_GRP_SIG].cond[13:8] == '0)
    else $error("frame test event missing");

  // signalling condition bits
  AST_SIG_COND: assert property (
    ##1 {st_reg.grp[CSG_GRP_SIG].cond[CSG_SIG_RAMP], st_reg.grp[CSG_GRP_SIG].cond[7:5]}
    == {$past(sig_ind_i.ramping), $past(sig_ind_i.svc_opt2),
        $past(sig_ind_i.hard_handoff), $past(sig_ind_i.softer_handoff)})
    else $error("signalling condition wrong");

  // alert needs ringing and option one
  AST_ALERT: assert property (
    ##1 st_reg.grp[CSG_GRP_SIG].cond[CSG_SIG_ALERT] ==
    ($past(sig_ind_i.mobile_ringing) && $past(sig_ind_i.svc_opt1_orig)))
    else $error("alert condition wrong");

  // rising edge with filter
  AST_RISE_EVT: assert property (
    !st_reg.grp[CSG_GRP_CALL].cond[CSG_CALL_ACT] && call_ind_i.active
    && st_reg.grp[CSG_GRP_CALL].rise[CSG_CALL_ACT]
    |=> st_reg.grp[CSG_GRP_CALL].evt[CSG_CALL_ACT])
    else $error("rising edge event missing");

  // summary from event and enable
  AST_SUMMARY: assert property (
    st_reg.grp[CSG_GRP_CALL].evt[CSG_CALL_CONN] && st_reg.grp[CSG_GRP_CALL].ena[CSG_CALL_CONN]
    |-> call_summary_o)
    else $error("summary not raised");

  // falling edge with filter
  AST_FALL_EVT: assert property (
    st_reg.grp[CSG_GRP_CALL].cond[CSG_CALL_ACT] && !call_ind_i.active
    && st_reg.grp[CSG_GRP_CALL].fall[CSG_CALL_ACT]
    |=> st_reg.grp[CSG_GRP_CALL].evt[CSG_CALL_ACT])
    else $error("falling edge event missing");

  // a write gets no answer
  AST_WR_SILENT: assert property (
    cmd_i.valid && cmd_i.write |=> !rsp_valid_o)
    else $error("write answered");

  // every read answered next cycle
  AST_RD_ANSWER: assert property (
    cmd_i.valid && !cmd_i.write |=> rsp_valid_o)
    else $error("read not answered");

  // clear-status empties signalling events
  AST_SIG_CLR: assert property (
    clear_status_i |=> st_reg.grp[CSG_GRP_SIG].evt == $past(set_sig))
    else $error("signalling events not cleared");

  // no alert without option one
  AST_ALERT_OFF: assert property (
    !sig_ind_i.svc_opt1_orig |=> !st_reg.grp[CSG_GRP_SIG].cond[CSG_SIG_ALERT])
    else $error("alert without option one");

  // condition ignores host writes
  AST_WR_COND: assert property (
    hit_call && cmd_i.write && cmd_i.sel == CSG_SEL_COND
    |=> st_reg.grp[CSG_GRP_CALL].cond == $past(call_c))
    else $error("condition took a write");

  // enable write stored masked
  AST_ENA_WR: assert property (
    hit_sig && cmd_i.write && cmd_i.sel == CSG_SEL_ENA
    |=> st_reg.grp[CSG_GRP_SIG].ena == ($past(cmd_i.data) & CSG_SIG_MASK))
    else $error("enable write lost");

  // ringing holds until answered
  AST_RING_HOLD: assert property (
    st_reg.ring && !call_ind_i.answered |=> st_reg.ring)
    else $error("ringing dropped early");

  // filters change only on writes
  AST_RISE_HOLD: assert property (
    !(hit_call && cmd_i.write)
    |=> st_reg.grp[CSG_GRP_CALL].rise == $past(st_reg.grp[CSG_GRP_CALL].rise))
    else $error("rise filter changed unasked");
endmodule
`default_nettype wire

// file: verification/csg_host_model.sv
// host model: issues status queries and writes to the status groups
// assumes clk_i is the block clock; requests change just after rising edges
`default_nettype none
module csg_host_model (
  input  wire logic          clk_i,        // block clock
  input  wire logic          rsp_valid_i,  // read answer strobe
  input  wire logic [15:0]   rsp_data_i,   // read answer word
  output var csg_pkg::csg_cmd_type cmd_o   // query strobe and payload
);
  timeunit 1ns;
  timeprecision 1ps;
  import csg_pkg::*;
  // ==========================================================
  // idle bus
  initial cmd_o = '0;
  // write one register; no answer is expected, data scrambled on release
  task automatic wr(input logic g, input logic [2:0] s, input logic [15:0] d);
    @(posedge clk_i);
    cmd_o <= '{valid: 1'b1, grp: g, sel: s, write: 1'b1, data: d};
    @(posedge clk_i);
    cmd_o.valid <= 1'b0;
    cmd_o.data  <= ~d;
  endtask
  // read one register after gap idle cycles; answer taken one cycle on
  task automatic rd(input logic g, input logic [2:0] s, output logic [15:0] d,
                    output logic ok, input int gap = 0);
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    cmd_o <= '{valid: 1'b1, grp: g, sel: s, write: 1'b0, data: 16'hA5A5};
    @(posedge clk_i);
    cmd_o.valid <= 1'b0;
    cmd_o.data  <= 16'h5A5A;
    #1;
    ok = rsp_valid_i;
    d  = rsp_data_i;
  endtask
endmodule
`default_nettype wire

// file: verification/csg_status_groups_test.sv
// testbench for the call-state and signalling status groups
// assumes csg_pkg compiled first and the host model drives the query port
`default_nettype none
module csg_status_groups_test;
  timeunit 1ns;
  timeprecision 1ps;
  import csg_pkg::*;
  // ==========================================================
  // signals
  logic             clk_i        = 1'b0;  // 40 MHz clock
  logic             rst_i        = 1'b1;  // async reset
  csg_call_ind_type call_ind     = '0;    // call indicators
  csg_sig_ind_type  sig_ind      = '0;    // signalling levels and pulses
  csg_cmd_type      cmd;                  // host query
  logic             clear_status = 1'b0;  // clear-status pulse
  logic             oper_en      = 1'b0;  // operation group enable
  logic             rsp_valid;            // read strobe
  logic [15:0]      rsp_data;             // read word
  logic             call_sum;             // call summary
  logic             sig_sum;              // signalling summary
  logic             sig_byte;             // status byte bit
  int               err_total    = 0;     // mismatches
  int               n_checks     = 0;     // comparisons
  localparam logic [10:0] PULSE [5] = '{11'h010, 11'h008, 11'h004, 11'h002, 11'h001};
  localparam int          PPOS  [5] = '{CSG_SIG_RATE, CSG_SIG_PILOT, CSG_SIG_PASS,
                                        CSG_SIG_FAIL, CSG_SIG_MAXF};
  localparam logic [10:0] LEVEL [5] = '{11'h400, 11'h200, 11'h100, 11'h080, 11'h060};
  localparam int          LPOS  [5] = '{CSG_SIG_RAMP, CSG_SIG_SO2, CSG_SIG_HARD,
                                        CSG_SIG_SOFTER, CSG_SIG_ALERT};
  always #12.5 clk_i = ~clk_i;  // clock generator
  // ==========================================================
  // design and host
  csg_status_groups u_csg_status_groups (.clk_i(clk_i), .rst_i(rst_i), .call_ind_i(call_ind),
    .sig_ind_i(sig_ind), .cmd_i(cmd), .clear_status_i(clear_status),
    .oper_sig_enable_i(oper_en), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data),
    .call_summary_o(call_sum), .sig_summary_o(sig_sum), .sig_status_byte_o(sig_byte));
  csg_host_model u_csg_host_model (.clk_i(clk_i), .rsp_valid_i(rsp_valid),
    .rsp_data_i(rsp_data), .cmd_o(cmd));
  // ==========================================================
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // read and compare, answer strobe included
  task automatic rq(input logic g, input logic [2:0] s, input logic [15:0] exp,
                    input string what, input int gap = 0);
    logic [15:0] d;
    logic        ok;
    u_csg_host_model.rd(g, s, d, ok, gap);
    chk({15'h0000, ok}, 16'h0001, "answer strobe");
    chk(d, exp, what);
  endtask
  // one-cycle signalling pulse
  task automatic pulse(input logic [10:0] p);
    @(posedge clk_i);
    sig_ind <= csg_sig_ind_type'(p);
    @(posedge clk_i);
    sig_ind <= '0;
  endtask
  // one-cycle clear-status pulse
  task automatic clr();
    @(posedge clk_i);
    clear_status <= 1'b1;
    @(posedge clk_i);
    clear_status <= 1'b0;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    for (int g = 0; g < 2; g++) begin
      for (int s = 0; s < 6; s++) begin
        rq(g[0], s[2:0], 16'h0000, "reset value", s);
      end
    end
  endtask
  task automatic t_call_cond();
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_i);
      call_ind <= csg_call_ind_type'(9'h001 << i);
      rq(CSG_GRP_CALL, CSG_SEL_COND, 16'h0001 << i, "call cond");
    end
    rq(CSG_GRP_CALL, CSG_SEL_COND, 16'h0020, "cond reread");
    rq(CSG_GRP_SIG, CSG_SEL_EVT, 16'h0001 << CSG_SIG_REGD, "registered event");
    @(posedge clk_i);
    call_ind <= '{base_call_tried: 1'b1, past_access: 1'b1, default: 1'b0};
    rq(CSG_GRP_CALL, CSG_SEL_COND, 16'h0040, "ringing set");
    @(posedge clk_i);
    call_ind <= '0;
    rq(CSG_GRP_CALL, CSG_SEL_COND, 16'h0040, "ringing held");
    @(posedge clk_i);
    call_ind.answered <= 1'b1;
    rq(CSG_GRP_CALL, CSG_SEL_COND, 16'h0000, "answer clears");
    @(posedge clk_i);
    call_ind <= '0;
  endtask
  task automatic t_filters();
    logic [15:0] exp;
    for (int g = 0; g < 2; g++) begin
      exp = g ? CSG_SIG_MASK : CSG_CALL_MASK;
      u_csg_host_model.wr(g[0], CSG_SEL_RISE, 16'hFFFF);
      u_csg_host_model.wr(g[0], CSG_SEL_FALL, 16'hAAAA);
      u_csg_host_model.wr(g[0], CSG_SEL_COND, 16'hFFFF);
      rq(g[0], CSG_SEL_RISE, exp, "rise filter");
      rq(g[0], CSG_SEL_FALL, exp & 16'hAAAA, "fall filter");
      rq(g[0], CSG_SEL_COND, 16'h0000, "cond not writable");
      u_csg_host_model.wr(g[0], CSG_SEL_RISE, 16'h0000);
      u_csg_host_model.wr(g[0], CSG_SEL_FALL, 16'h0000);
    end
  endtask
  task automatic t_edges();
    u_csg_host_model.wr(CSG_GRP_CALL, CSG_SEL_RISE, 16'h0021);
    u_csg_host_model.wr(CSG_GRP_CALL, CSG_SEL_FALL, 16'h0001);
    u_csg_host_model.wr(CSG_GRP_CALL, CSG_SEL_ENA, 16'h0021);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_i);
      call_ind <= csg_call_ind_type'(9'h021);
      @(posedge clk_i);
      call_ind <= csg_call_ind_type'(9'h020);
      repeat (2) @(posedge clk_i);
      #1;
      chk({15'h0000, call_sum}, 16'h0001, "call summary set");
    end
    rq(CSG_GRP_CALL, CSG_SEL_EVT, 16'h0021, "edge events");
    rq(CSG_GRP_CALL, CSG_SEL_EVT, 16'h0000, "event read clears");
    chk({15'h0000, call_sum}, 16'h0000, "call summary cleared");
    u_csg_host_model.wr(CSG_GRP_CALL, CSG_SEL_ENA, 16'h0000);
    rq(CSG_GRP_CALL, CSG_SEL_ENA, 16'h0000, "enable cleared");
  endtask
  task automatic t_sig();
    u_csg_host_model.wr(CSG_GRP_SIG, CSG_SEL_ENA, 16'h2000);
    pulse(PULSE[0]);
    @(posedge clk_i);
    #1;
    chk({14'h0000, sig_sum, sig_byte}, 16'h0002, "byte gated off");
    @(posedge clk_i);
    oper_en <= 1'b1;
    #1;
    chk({15'h0000, sig_byte}, 16'h0001, "byte passes");
    for (int i = 0; i < 5; i++) begin
      pulse(PULSE[i]);
      rq(CSG_GRP_SIG, CSG_SEL_EVT, 16'h0001 << PPOS[i], "event bit");
    end
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_i);
      sig_ind <= csg_sig_ind_type'(LEVEL[i]);
      rq(CSG_GRP_SIG, CSG_SEL_COND, 16'h0001 << LPOS[i], "sig cond");
    end
    @(posedge clk_i);
    sig_ind <= csg_sig_ind_type'(11'h040);
    rq(CSG_GRP_SIG, CSG_SEL_COND, 16'h0000, "alert needs option one");
    @(posedge clk_i);
    sig_ind <= '0;
    pulse(PULSE[1]);
    clr();
    rq(CSG_GRP_SIG, CSG_SEL_EVT, 16'h0000, "clear status");
  endtask
  // ==========================================================
  // verdict and run control
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_call_cond();
    t_filters();
    t_edges();
    t_sig();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude();
  end
endmodule
`default_nettype wire
